// ### hw/dcel_regs.svh
`ifndef DCEL_REGS_SVH
`define DCEL_REGS_SVH
`define DCEL_ADDR_W 9
`define DCEL_OFF_CTRL 9'h1F8
`define DCEL_OFF_IEN 9'h1FA
`define DCEL_OFF_FILT 9'h1FC
`define DCEL_RST_CTRL 8'h00
`define DCEL_RST_IEN 8'h00
`define DCEL_RST_FILT 8'h00
`define DCEL_CTRL_EN_1 0
`define DCEL_CTRL_MON_1 3
`define DCEL_CTRL_EN_3 4
`define DCEL_CTRL_MON_3 7
`define DCEL_CTRL_WMASK 8'h77
`define DCEL_IEN_EN_1 2
`define DCEL_IEN_PL_1 3
`define DCEL_IEN_EN_3 6
`define DCEL_IEN_PL_3 7
`define DCEL_FILT_LO_1 2
`define DCEL_FILT_LO_3 6
`define DCEL_DIV_F8 5'd7
`define DCEL_DIV_F32 5'd31
`define DCEL_MATCH_CNT 2'd3
`define DCEL_STAB_US 100
`define DCEL_CLK_MHZ 100
`define DCEL_STAB_CYC (`DCEL_STAB_US * `DCEL_CLK_MHZ)
`endif

// ### hw/dcel_pkg.sv
package dcel_pkg;
    typedef enum logic [1:0] {
        FILT_NONE,
        FILT_F1,
        FILT_F8,
        FILT_F32
    } dcel_filt_type;
endpackage

// ### hw/dcel_chan.sv
`timescale 1ns/1ps
`include "dcel_regs.svh"
module dcel_chan (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cmp_level,
    input wire logic chan_irq_enable,
    input wire logic chan_both_edge_select,
    input wire logic edge_sense_bit,
    input wire logic [1:0] filt_sel,
    input wire logic tick_f8,
    input wire logic tick_f32,
    output logic request_pulse
);
    typedef struct packed {
        logic [2:0] shift;
        logic filt_lvl;
    } dcel_chan_st_type;
    dcel_chan_st_type st_q, st_d;
    logic tick, new_lvl, chg, edge_ok;
    dcel_pkg::dcel_filt_type fsel;
    // ================================
    // three-sample filter
    always_comb
    begin
        st_d = st_q;
        fsel = dcel_pkg::dcel_filt_type'(filt_sel);
        case (fsel)
            dcel_pkg::FILT_NONE: tick = 1'b1;
            dcel_pkg::FILT_F1: tick = 1'b1;
            dcel_pkg::FILT_F8: tick = tick_f8;
            dcel_pkg::FILT_F32: tick = tick_f32;
            default: tick = 1'b1;
        endcase
        new_lvl = st_q.filt_lvl;
        if (fsel == dcel_pkg::FILT_NONE)
            new_lvl = cmp_level;
        else if (tick)
        begin
            st_d.shift = {st_q.shift[1:0], cmp_level};
            if (&st_d.shift)
                new_lvl = 1'b1;
            else if (~|st_d.shift)
                new_lvl = 1'b0;
        end
        st_d.filt_lvl = new_lvl;
        chg = new_lvl != st_q.filt_lvl;
        // one edge: edge sense 0 selects falling, 1 rising
        edge_ok = chan_both_edge_select | (new_lvl == edge_sense_bit);
        request_pulse = chg & edge_ok & chan_irq_enable;
    end
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    filt_match_a: assert property (@(posedge ref_clk) disable iff (srst)
        (filt_sel != 2'b00 && request_pulse) |-> (st_d.shift == 3'b111 || st_d.shift == 3'b000))
        else $error("filtered request without three matching samples");
    no_req_dis_a: assert property (@(posedge ref_clk) disable iff (srst)
        !chan_irq_enable |-> !request_pulse)
        else $error("request while channel interrupt disabled");
endmodule // dcel_chan

// ### hw/dcel_top.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "dcel_regs.svh"
// How it works
// - control bits 0 and 4 enable comparator one and three
// - monitor flag is one when analog above reference, zero when disabled
// - monitor flags are read only, writes ignored
// - per-channel interrupt enable gates change requests
// - polarity bit: zero one edge, one both edges
// - rewriting input enable register may set pending flag spuriously
// - two-bit filter field: none, f1, f8, f32 sampling
// - filtered request only after three matching consecutive samples
// - each qualifying result change raises a request when enabled
// - both channels independent, identical, share only addresses and the sampling prescaler
// - request drives same pending flag as external input of same index
module dcel_top (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] cmp_above,
    input wire logic [1:0] edge_sense_bit,
    input wire logic [1:0] ext_req,
    input wire logic [1:0] pending_clear,
    output logic [1:0] pending_request_flag,
    output logic [1:0] cmp_enable
);
    // cmp_above[0] is the raw analog_in_pin > reference_in_pin result of comparator one
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] ien;
        logic [7:0] filt;
        logic [7:0] rdata;
        logic [1:0] pend;
        logic [4:0] div;
        logic [1:0] s1;
        logic [1:0] s2;
    } dcel_st_type;
    dcel_st_type st_q, st_d;
    logic [1:0] req;
    logic [1:0] mon;
    logic [1:0] spurious;
    logic tick_f8, tick_f32;
    // ================================
    // prescaler for sampling clocks
    assign tick_f8 = (st_q.div[2:0] == 3'(`DCEL_DIV_F8));
    assign tick_f32 = (st_q.div == `DCEL_DIV_F32);
    // ================================
    // channels
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            localparam int EN_B = g ? `DCEL_CTRL_EN_3 : `DCEL_CTRL_EN_1;
            localparam int IE_B = g ? `DCEL_IEN_EN_3 : `DCEL_IEN_EN_1;
            localparam int PL_B = g ? `DCEL_IEN_PL_3 : `DCEL_IEN_PL_1;
            localparam int FL_B = g ? `DCEL_FILT_LO_3 : `DCEL_FILT_LO_1;
            // disabled comparator reads low
            assign mon[g] = st_q.s2[g] & st_q.ctrl[EN_B];
            assign cmp_enable[g] = st_q.ctrl[EN_B];
            // write to input enable may flag a change of this channel's bits
            assign spurious[g] = reg_wr && reg_addr == `DCEL_OFF_IEN &&
                (reg_wdata[PL_B] != st_q.ien[PL_B] || reg_wdata[IE_B] != st_q.ien[IE_B]) &&
                reg_wdata[IE_B];
            dcel_chan u_chan (
                .ref_clk(ref_clk),
                .srst(srst),
                .cmp_level(mon[g]),
                .chan_irq_enable(st_q.ien[IE_B]),
                .chan_both_edge_select(st_q.ien[PL_B]),
                .edge_sense_bit(edge_sense_bit[g]),
                .filt_sel(st_q.filt[FL_B+1:FL_B]),
                .tick_f8(tick_f8),
                .tick_f32(tick_f32),
                .request_pulse(req[g])
            );
        end
    endgenerate
    // ================================
    // register file and pending flags
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = cmp_above;
        st_d.s2 = st_q.s1;
        st_d.div = st_q.div + 5'd1;
        st_d.rdata = 8'h00;
        if (reg_wr)
        begin
            case (reg_addr)
                `DCEL_OFF_CTRL: st_d.ctrl = reg_wdata & `DCEL_CTRL_WMASK;
                `DCEL_OFF_IEN: st_d.ien = reg_wdata;
                `DCEL_OFF_FILT: st_d.filt = reg_wdata;
                default: st_d.ien = st_q.ien;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                `DCEL_OFF_CTRL: st_d.rdata = {mon[1], st_q.ctrl[6:4], mon[0], st_q.ctrl[2:0]};
                `DCEL_OFF_IEN: st_d.rdata = st_q.ien;
                `DCEL_OFF_FILT: st_d.rdata = st_q.filt;
                default: st_d.rdata = 8'h00;
            endcase
        end
        // set wins over clear
        st_d.pend = (st_q.pend & ~pending_clear) | req | ext_req | spurious;
    end
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_q.ctrl <= `DCEL_RST_CTRL;
            st_q.ien <= `DCEL_RST_IEN;
            st_q.filt <= `DCEL_RST_FILT;
            st_q.rdata <= 8'h00;
            st_q.pend <= 2'b00;
            st_q.div <= 5'd0;
            st_q.s1 <= 2'b00;
            st_q.s2 <= 2'b00;
        end
        else
            st_q <= st_d;
    end
    assign reg_rdata = st_q.rdata;
    assign pending_request_flag = st_q.pend;
    // ================================
    // checks
    mon_dis_a: assert property (@(posedge ref_clk) disable iff (srst)
        (reg_rd && reg_addr == `DCEL_OFF_CTRL && !st_q.ctrl[0]) |=> !reg_rdata[3])
        else $error("monitor flag high while comparator disabled");
    mon_ro_a: assert property (@(posedge ref_clk) disable iff (srst)
        reg_wr |=> (st_q.ctrl[3] == 1'b0 && st_q.ctrl[7] == 1'b0))
        else $error("monitor bit stored from write");
    en_write_a: assert property (@(posedge ref_clk) disable iff (srst)
        (reg_wr && reg_addr == `DCEL_OFF_CTRL) |=> cmp_enable == {$past(reg_wdata[4]), $past(reg_wdata[0])})
        else $error("enable bits not taken from write");
    req_sets_a: assert property (@(posedge ref_clk) disable iff (srst)
        req[0] |=> pending_request_flag[0])
        else $error("request did not set pending flag");
    set_wins_a: assert property (@(posedge ref_clk) disable iff (srst)
        ((req[1] || ext_req[1]) && pending_clear[1]) |=> pending_request_flag[1])
        else $error("clear beat simultaneous set");
    rd_data_a: assert property (@(posedge ref_clk) disable iff (srst)
        (reg_rd && reg_addr == `DCEL_OFF_FILT) |=> reg_rdata == $past(st_q.filt))
        else $error("filter register readback wrong");
    ind_ch_a: assert property (@(posedge ref_clk) disable iff (srst)
        (!st_q.ien[`DCEL_IEN_EN_3]) |-> !req[1])
        else $error("channel three request while disabled");
    unf_resp_a: assert property (@(posedge ref_clk) disable iff (srst)
        (st_q.filt[3:2] == 2'b00 && st_q.ien[2] && st_q.ien[3] && $changed(mon[0])
         && $stable(st_q.filt) && $stable(st_q.ien)) |-> req[0])
        else $error("unfiltered change missed");
    req_c: cover property (@(posedge ref_clk) req[0]);
    req3_c: cover property (@(posedge ref_clk) req[1] && st_q.filt[7:6] == 2'b11);
    spur_c: cover property (@(posedge ref_clk) spurious[0]);
endmodule // dcel_top

// ### verification/dcel_analog_model.sv
`timescale 1ns/1ps
// ====================================================
// analog comparator front end
// ====================================================
module dcel_analog_model (
    input wire logic [15:0] ana_lvl,
    input wire logic [15:0] ref_lvl,
    output logic [1:0] cmp_above
);
    // delay keeps the result change off the clock edge, as a real comparator would
    assign #3 cmp_above[0] = ana_lvl[7:0] > ref_lvl[7:0];
    assign #3 cmp_above[1] = ana_lvl[15:8] > ref_lvl[15:8];
endmodule // dcel_analog_model

// ### verification/dual_comparator_event_logic_tb.sv
`timescale 1ns/1ps
module dual_comparator_event_logic_tb;
    logic ref_clk = 1'h0;
    logic srst = 1'h1;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [15:0] ana_lvl = 16'h1010;
    logic [15:0] ref_lvl = 16'h8080;
    logic [1:0] cmp_above, pending_request_flag, cmp_enable;
    logic [1:0] edge_sense_bit = 2'h3;
    logic [1:0] ext_req = 2'h0;
    logic [1:0] pending_clear = 2'h0;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    int dv;
    dcel_analog_model i_model (.ana_lvl(ana_lvl), .ref_lvl(ref_lvl), .cmp_above(cmp_above));
    dcel_top i_dut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmp_above(cmp_above), .edge_sense_bit(edge_sense_bit), .ext_req(ext_req),
        .pending_clear(pending_clear), .pending_request_flag(pending_request_flag),
        .cmp_enable(cmp_enable));
    // ====================================================
    // clock, timeout, helpers
    // ====================================================
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, exp);
    endtask
    // rewriting the enable register may leave a stale request, so tests clear first
    task automatic clr();
        @(posedge ref_clk);
        pending_clear <= 2'h3;
        @(posedge ref_clk);
        pending_clear <= 2'h0;
    endtask
    task automatic set_ana(input logic [15:0] v);
        @(posedge ref_clk);
        ana_lvl <= v;
    endtask
    task automatic wait_pend(input int idx, output int cnt);
        cnt = 0;
        while (pending_request_flag[idx] !== 1'h1 && cnt < 400)
        begin
            @(posedge ref_clk);
            #1 cnt++;
        end
    endtask
    // ====================================================
    // main sequence
    // ====================================================
    initial
    begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'h0;
        rd(9'h1F8, 8'h00);
        rd(9'h1FA, 8'h00);
        rd(9'h1FC, 8'h00);
        rd(9'h100, 8'h00);
        wr(9'h1F8, 8'hFF);
        rd(9'h1F8, 8'h77);
        chk({6'h00, cmp_enable}, 8'h03);
        wr(9'h1F8, 8'h01);
        set_ana(16'hF0F0);
        repeat (6) @(posedge ref_clk);
        rd(9'h1F8, 8'h09);
        chk({6'h00, pending_request_flag}, 8'h00);
        set_ana(16'h1010);
        wr(9'h1F8, 8'h11);
        wr(9'h1FA, 8'h04);
        repeat (6) @(posedge ref_clk);
        clr();
        set_ana(16'h10F0);
        wait_pend(0, n);
        chk(8'(n <= 6), 8'h01);
        chk({7'h00, pending_request_flag[1]}, 8'h00);
        clr();
        set_ana(16'h1010);
        repeat (10) @(posedge ref_clk);
        chk({6'h00, pending_request_flag}, 8'h00);
        edge_sense_bit <= 2'h2;
        wr(9'h1FA, 8'h0C);
        clr();
        set_ana(16'h10F0);
        wait_pend(0, n);
        chk(8'(n <= 6), 8'h01);
        clr();
        set_ana(16'h1010);
        wait_pend(0, n);
        chk(8'(n <= 6), 8'h01);
        wr(9'h1FA, 8'h04);
        clr();
        set_ana(16'h10F0);
        repeat (10) @(posedge ref_clk);
        chk({6'h00, pending_request_flag}, 8'h00);
        set_ana(16'h1010);
        wait_pend(0, n);
        chk(8'(n <= 6), 8'h01);
        wr(9'h1FA, 8'h00);
        clr();
        set_ana(16'h10F0);
        repeat (10) @(posedge ref_clk);
        chk({6'h00, pending_request_flag}, 8'h00);
        @(posedge ref_clk);
        ext_req <= 2'h2;
        pending_clear <= 2'h2;
        @(posedge ref_clk);
        ext_req <= 2'h0;
        pending_clear <= 2'h0;
        repeat (3) @(posedge ref_clk);
        chk({6'h00, pending_request_flag}, 8'h02);
        wr(9'h1FA, 8'h40);
        for (int k = 1; k < 4; k++)
        begin
            dv = (k == 1) ? 1 : (k == 2) ? 8 : 32;
            wr(9'h1FC, 8'(k << 6));
            set_ana(16'h1010);
            repeat (120) @(posedge ref_clk);
            clr();
            set_ana(16'hF010);
            wait_pend(1, n);
            chk(8'(n >= 2 * dv && n <= 3 * dv + 12), 8'h01);
        end
        end_of_test();
    end
endmodule // dual_comparator_event_logic_tb
